// >>> inc/clk_status_params.svh
// Offsets, field positions, reset values and band limits of the clock input status registers
`ifndef CLK_STATUS_PARAMS_SVH
`define CLK_STATUS_PARAMS_SVH

// ==========================================
// Register offsets
`define OFS_DIV_TOP 8'h2e
`define OFS_DIV_MID 8'h2f
`define OFS_DIV_LOW 8'h30
`define OFS_RATE_BAND 8'h37
`define OFS_ACTIVE 8'h80
`define OFS_LOSS 8'h81
`define OFS_ALARM 8'h82

// ==========================================
// Field positions
`define RATE_ONE_LSB 0
`define RATE_TWO_LSB 3
`define BIT_SKEW_BUSY 7
`define BIT_HOLD_VALID 6
`define READ_ZERO 8'h00

// ==========================================
// Reset values
`define RST_DIV_BYTE 8'h00
`define RST_DIV_TOP 3'h0
`define RST_RATE 3'h0

// ==========================================
// Band windows in MHz
`define BAND_MIN0 10'h00a
`define BAND_MAX0 10'h01b
`define BAND_MIN1 10'h019
`define BAND_MAX1 10'h036
`define BAND_MIN2 10'h032
`define BAND_MAX2 10'h069
`define BAND_MIN3 10'h05f
`define BAND_MAX3 10'h0d7
`define BAND_MIN4 10'h0be
`define BAND_MAX4 10'h1b3
`define BAND_MIN5 10'h177
`define BAND_MAX5 10'h2c6

`endif

// >>> inc/clk_status_pkg.sv
// Types shared by the clock input status register bank
package clk_status_pkg;
   typedef logic [2:0] rate_band_t;

   typedef struct packed {
      logic [9:0] lowMhz;
      logic [9:0] highMhz;
      logic valid;
   } band_window_t;

   typedef struct packed {
      logic [7:0] divLow;
      logic [7:0] divMid;
      logic [2:0] divTop;
      rate_band_t rateOne;
      rate_band_t rateTwo;
      band_window_t bandOne;
      band_window_t bandTwo;
      logic [7:0] status;
      logic skewBusy;
      logic ackSeen;
      logic holdValid;
      logic [7:0] rdData;
      logic rdValid;
   } bank_state_t;
endpackage : clk_status_pkg

// >>> rtl/input_sync.sv
// Three-stage synchroniser whose output moves once the last two stages agree
`timescale 1ns/1ps
module input_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] raw,
   output logic [WIDTH-1:0] stable
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] out;
   } sync_state_t;

   sync_state_t st;
   sync_state_t next_st;

   // Stage one feeds stage two only; disagreement between two and three holds the old value
   always_comb begin
      next_st = st;
      next_st.s1 = raw;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.out = (st.s2 & st.s3) | (st.out & (st.s2 ^ st.s3));
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign stable = st.out;
endmodule : input_sync

// >>> rtl/holdover_history.sv
// Fill tracker for the holdover frequency history
`timescale 1ns/1ps
module holdover_history #(
   parameter int DEPTH = 256
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic sample,
   input wire logic restart,
   output logic filled
);
   typedef struct packed {
      logic [$clog2(DEPTH+1)-1:0] count;
      logic full;
   } hist_state_t;

   hist_state_t st;
   hist_state_t next_st;

   // A lost reference spoils the history, so filling starts over
   always_comb begin
      next_st = st;
      if (restart) begin
         next_st = '0;
      end else if (sample && !st.full) begin
         next_st.count = st.count + 1'b1;
         next_st.full = (st.count == ($clog2(DEPTH+1))'(DEPTH - 1));
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign filled = st.full;
endmodule : holdover_history

// >>> rtl/clock_input_status_registers.sv
// Register bank and live status reporting for the clock inputs, reference and PLL
`timescale 1ns/1ps
`include "clk_status_params.svh"
module clock_input_status_registers #(
   parameter int HISTORY_DEPTH = 256
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   output logic regRdValid,
   input wire logic inputOneSelected,
   input wire logic inputTwoSelected,
   input wire logic inputOneSignalLoss,
   input wire logic inputTwoSignalLoss,
   input wire logic referenceSignalLoss,
   input wire logic inputOneFreqOffset,
   input wire logic inputTwoFreqOffset,
   input wire logic pllUnlocked,
   input wire logic coarseSkewWrite,
   input wire logic coarseSkewAckToggle,
   input wire logic historySample,
   output logic [18:0] secondInputDivider,
   output clk_status_pkg::rate_band_t inputOneRateBand,
   output clk_status_pkg::rate_band_t inputTwoRateBand,
   output clk_status_pkg::band_window_t inputOneWindow,
   output clk_status_pkg::band_window_t inputTwoWindow,
   output logic inputOneActive,
   output logic inputTwoActive,
   output logic coarseSkewBusy,
   output logic holdoverHistoryValid
);
   import clk_status_pkg::*;

   // ==========================================
   // Helper functions
   function automatic band_window_t bandWindow(input rate_band_t code);
      band_window_t w;
      w = '0;
      w.valid = 1'b1;
      case (code)
         3'h0: begin
            w.lowMhz = `BAND_MIN0;
            w.highMhz = `BAND_MAX0;
         end
         3'h1: begin
            w.lowMhz = `BAND_MIN1;
            w.highMhz = `BAND_MAX1;
         end
         3'h2: begin
            w.lowMhz = `BAND_MIN2;
            w.highMhz = `BAND_MAX2;
         end
         3'h3: begin
            w.lowMhz = `BAND_MIN3;
            w.highMhz = `BAND_MAX3;
         end
         3'h4: begin
            w.lowMhz = `BAND_MIN4;
            w.highMhz = `BAND_MAX4;
         end
         3'h5: begin
            w.lowMhz = `BAND_MIN5;
            w.highMhz = `BAND_MAX5;
         end
         // Reserved codes give no window, so the monitor is told to stand idle
         default: begin
            w = '0;
         end
      endcase
      return w;
   endfunction : bandWindow

   function automatic logic hits(input logic [7:0] addr, input logic [7:0] ofs);
      return addr == ofs;
   endfunction : hits

   // An input counts as the PLL reference only while chosen and not lost
   function automatic logic activeFrom(input logic sel, input logic loss);
      return sel && !loss;
   endfunction : activeFrom

   // ==========================================
   // Synchronised live conditions
   logic [8:0] rawLive;
   logic [8:0] live;
   logic selOne;
   logic selTwo;
   logic lossOne;
   logic lossTwo;
   logic lossRef;
   logic fosOne;
   logic fosTwo;
   logic unlocked;
   logic skewAck;
   logic histFilled;
   logic actOne;
   logic actTwo;

   assign rawLive = {coarseSkewAckToggle, inputTwoSelected, inputOneSelected, inputTwoSignalLoss,
                     inputOneSignalLoss, referenceSignalLoss, inputTwoFreqOffset, inputOneFreqOffset,
                     pllUnlocked};

   // Every live condition comes from outside this clock, so all share one synchroniser
   input_sync #(
      .WIDTH(9)
   ) liveSync (
      .clk(clk),
      .resetn(resetn),
      .raw(rawLive),
      .stable(live)
   );

   assign {skewAck, selTwo, selOne, lossTwo, lossOne, lossRef, fosTwo, fosOne, unlocked} = live;
   assign actOne = activeFrom(selOne, lossOne);
   assign actTwo = activeFrom(selTwo, lossTwo);

   // History is meaningless once no input drives the PLL
   holdover_history #(
      .DEPTH(HISTORY_DEPTH)
   ) history (
      .clk(clk),
      .resetn(resetn),
      .sample(historySample),
      .restart(!actOne && !actTwo),
      .filled(histFilled)
   );

   // ==========================================
   // Bank state
   bank_state_t st;
   bank_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.rdValid = 1'b0;
      // Writes to the read-only offsets fall through untouched
      if (regWrite) begin
         if (hits(regAddr, `OFS_DIV_LOW)) begin
            next_st.divLow = regWrData;
         end
         if (hits(regAddr, `OFS_DIV_MID)) begin
            next_st.divMid = regWrData;
         end
         if (hits(regAddr, `OFS_DIV_TOP)) begin
            next_st.divTop = regWrData[2:0];
         end
         if (hits(regAddr, `OFS_RATE_BAND)) begin
            next_st.rateOne = regWrData[`RATE_ONE_LSB +: 3];
            next_st.rateTwo = regWrData[`RATE_TWO_LSB +: 3];
         end
      end
      // Window follows the band code on the same edge, so after a write the monitor never sees a stale pair
      next_st.bandOne = bandWindow(next_st.rateOne);
      next_st.bandTwo = bandWindow(next_st.rateTwo);
      // Bit order: 7-6 zero, 5 act2, 4 act1, 3 los2, 2 los1, 1 losRef, 0 spare
      next_st.status = {1'b0, 1'b0, actTwo, actOne, lossTwo, lossOne, lossRef, 1'b0};
      next_st.holdValid = histFilled;
      // Acknowledge toggle marks the engine finishing; a new write in the same cycle keeps busy set
      next_st.ackSeen = skewAck;
      if (coarseSkewWrite) begin
         next_st.skewBusy = 1'b1;
      end else if (skewAck != st.ackSeen) begin
         next_st.skewBusy = 1'b0;
      end
      // Reads see the contents from before any write in the same cycle
      if (regRead) begin
         next_st.rdValid = 1'b1;
         next_st.rdData = `READ_ZERO;
         if (hits(regAddr, `OFS_DIV_LOW)) begin
            next_st.rdData = st.divLow;
         end else if (hits(regAddr, `OFS_DIV_MID)) begin
            next_st.rdData = st.divMid;
         end else if (hits(regAddr, `OFS_DIV_TOP)) begin
            next_st.rdData = {5'h00, st.divTop};
         end else if (hits(regAddr, `OFS_RATE_BAND)) begin
            next_st.rdData = {2'h0, st.rateTwo, st.rateOne};
         end else if (hits(regAddr, `OFS_ACTIVE)) begin
            next_st.rdData = {6'h00, st.status[5], st.status[4]};
         end else if (hits(regAddr, `OFS_LOSS)) begin
            next_st.rdData = {5'h00, st.status[3:1]};
         end else if (hits(regAddr, `OFS_ALARM)) begin
            next_st.rdData = {st.skewBusy, st.holdValid, 3'h0, fosTwo, fosOne, unlocked};
         end
      end
   end

   // Offset and unlock alarm bits are sampled directly from the synchroniser at read time, so they are not latched; busy and hold valid are state flops
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st.divLow <= `RST_DIV_BYTE;
         st.divMid <= `RST_DIV_BYTE;
         st.divTop <= `RST_DIV_TOP;
         st.rateOne <= `RST_RATE;
         st.rateTwo <= `RST_RATE;
         // Windows stay cleared for one edge after reset, until the band code is decoded
         st.bandOne <= '0;
         st.bandTwo <= '0;
         st.status <= '0;
         st.skewBusy <= 1'b0;
         st.ackSeen <= 1'b0;
         st.holdValid <= 1'b0;
         st.rdData <= `READ_ZERO;
         st.rdValid <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================
   // Outputs, all straight from the state flops
   assign regRdData = st.rdData;
   assign regRdValid = st.rdValid;
   assign secondInputDivider = {st.divTop, st.divMid, st.divLow};
   assign inputOneRateBand = st.rateOne;
   assign inputTwoRateBand = st.rateTwo;
   assign inputOneWindow = st.bandOne;
   assign inputTwoWindow = st.bandTwo;
   assign inputOneActive = st.status[4];
   assign inputTwoActive = st.status[5];
   assign coarseSkewBusy = st.skewBusy;
   assign holdoverHistoryValid = st.holdValid;

   // ==========================================
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   div_low_write_a: assert property (regWrite && regAddr == `OFS_DIV_LOW |=>
      secondInputDivider[7:0] == $past(regWrData))
      else $error("divider low byte not stored");

   div_top_write_a: assert property (regWrite && regAddr == `OFS_DIV_TOP |=>
      secondInputDivider[18:16] == $past(regWrData[2:0]))
      else $error("divider top bits not stored");

   rate_field_a: assert property (regWrite && regAddr == `OFS_RATE_BAND ##1 regRead && regAddr == `OFS_RATE_BAND
      |=> regRdData[7:6] == 2'h0 && regRdData[5:0] == $past(regWrData[5:0], 2))
      else $error("rate band readback wrong");

   band_window_a: assert property (inputOneRateBand == 3'h3 |->
      inputOneWindow.valid && inputOneWindow.lowMhz == `BAND_MIN3 && inputOneWindow.highMhz == `BAND_MAX3)
      else $error("band window decode wrong");

   reserved_band_a: assert property (inputTwoWindow.valid |-> inputTwoRateBand[2:1] != 2'h3)
      else $error("reserved band gave a window");

   active_read_a: assert property (regRead && regAddr == `OFS_ACTIVE |=>
      regRdValid && regRdData == {6'h00, $past(inputTwoActive), $past(inputOneActive)})
      else $error("active input readback wrong");

   active_loss_a: assert property (inputOneActive |-> $past(lossOne) == 1'b0)
      else $error("input one active during loss");

   loss_live_a: assert property (regRead && regAddr == `OFS_LOSS |=>
      regRdData == {5'h00, $past(lossTwo, 2), $past(lossOne, 2), $past(lossRef, 2)})
      else $error("loss status readback wrong");

   alarm_read_a: assert property (regRead && regAddr == `OFS_ALARM |=>
      regRdData[2:0] == $past({fosTwo, fosOne, unlocked}) && regRdData[5:3] == 3'h0)
      else $error("alarm status readback wrong");

   skew_busy_a: assert property (coarseSkewWrite |=> coarseSkewBusy [*2])
      else $error("coarse skew busy not raised");

   hold_valid_a: assert property ($rose(holdoverHistoryValid) |-> $past(histFilled))
      else $error("holdover valid rose without full history");

   ro_write_a: assert property (regWrite && regAddr == `OFS_ALARM |=> $stable(secondInputDivider))
      else $error("read-only write changed state");

   // Writes store, read-only writes and idle cycles leave state alone, and readback mirrors what the bank holds in the cycle of the read
   div_mid_write_a: assert property (regWrite && regAddr == `OFS_DIV_MID |=>
      secondInputDivider[15:8] == $past(regWrData))
      else $error("divider middle byte not stored");

   div_low_read_a: assert property (regRead && regAddr == `OFS_DIV_LOW |=>
      regRdValid && regRdData == $past(secondInputDivider[7:0]))
      else $error("divider low byte readback wrong");

   div_top_read_a: assert property (regRead && regAddr == `OFS_DIV_TOP |=>
      regRdData == {5'h00, $past(secondInputDivider[18:16])})
      else $error("divider top bits readback wrong");

   rate_read_a: assert property (regRead && regAddr == `OFS_RATE_BAND |=>
      regRdData == {2'h0, $past(inputTwoRateBand), $past(inputOneRateBand)})
      else $error("rate band register readback wrong");

   rate_ro_write_a: assert property (regWrite && regAddr == `OFS_ACTIVE |=>
      $stable(inputOneRateBand) && $stable(inputTwoRateBand))
      else $error("status write changed a rate band");

   loss_ro_write_a: assert property (regWrite && regAddr == `OFS_LOSS |=>
      $stable(secondInputDivider) && $stable(inputTwoRateBand))
      else $error("loss status write changed state");

   divider_stable_a: assert property (!regWrite |=> $stable(secondInputDivider))
      else $error("divider moved without a write");

   rate_stable_a: assert property (!regWrite |=> $stable({inputTwoRateBand, inputOneRateBand}))
      else $error("rate band moved without a write");

   active_pad_a: assert property (regRead && regAddr == `OFS_ACTIVE |=> regRdData[7:2] == 6'h00)
      else $error("active status reserved bits set");

   loss_pad_a: assert property (regRead && regAddr == `OFS_LOSS |=> regRdData[7:3] == 5'h00)
      else $error("loss status reserved bits set");

   // Spot checks of the window decode at code 1 and at the top end of the table, code 5
   band_one_code_a: assert property (inputOneRateBand == 3'h1 |->
      inputOneWindow.valid && inputOneWindow.lowMhz == `BAND_MIN1 && inputOneWindow.highMhz == `BAND_MAX1)
      else $error("band one window decode wrong");

   band_two_code_a: assert property (inputTwoRateBand == 3'h5 |->
      inputTwoWindow.valid && inputTwoWindow.lowMhz == `BAND_MIN5 && inputTwoWindow.highMhz == `BAND_MAX5)
      else $error("band five window decode wrong");

   // Active bits are never set for an input that was unselected a cycle before; only input two is also checked for loss here
   active_one_sel_a: assert property (inputOneActive |-> $past(selOne))
      else $error("input one active while unselected");

   active_two_sel_a: assert property (inputTwoActive |-> $past(selTwo) && !$past(lossTwo))
      else $error("input two active while unselected or lost");

   // Busy only rises on a skew write and is reported as it stands
   skew_idle_a: assert property (!coarseSkewBusy && !coarseSkewWrite |=> !coarseSkewBusy)
      else $error("coarse skew busy rose without a write");

   skew_read_a: assert property (regRead && regAddr == `OFS_ALARM |=>
      regRdData[7:6] == $past({coarseSkewBusy, holdoverHistoryValid}))
      else $error("busy or hold valid readback wrong");

   // Losing every reference must drop the holdover valid bit two edges later
   hold_drop_a: assert property (!actOne && !actTwo |-> ##2 !holdoverHistoryValid)
      else $error("holdover valid kept without a reference");

   hold_empty_a: assert property (!histFilled |=> !holdoverHistoryValid)
      else $error("holdover valid without full history");

   read_answer_c: cover property (regRead ##1 regRdValid);
   skew_done_c: cover property (coarseSkewBusy ##1 !coarseSkewBusy);
   hold_fill_c: cover property ($rose(holdoverHistoryValid));
   active_two_c: cover property ($rose(inputTwoActive));
   rate_write_c: cover property (regWrite && regAddr == `OFS_RATE_BAND);
endmodule : clock_input_status_registers

// >>> sim/skew_engine_model.sv
// Behavioural coarse skew engine that answers each skew write with an ack toggle unless a newer write arrives first
`timescale 1ns/1ps
module skew_engine_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic skewWrite,
   input wire logic [7:0] ackDelay,
   output logic ackToggle
);
   // ==========================================
   // Completion delay
   logic [8:0] count;
   // A newer write restarts the wait, as a real engine would rework the setting
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ackToggle <= 1'b0;
         count <= 9'h000;
      end else if (skewWrite) begin
         count <= {1'b0, ackDelay} + 9'h001;
      end else if (count == 9'h001) begin
         ackToggle <= ~ackToggle;
         count <= 9'h000;
      end else if (count > 9'h001) begin
         count <= count - 9'h001;
      end
   end
endmodule : skew_engine_model

// >>> sim/clock_input_status_registers_tb.sv
// Self-checking testbench for the clock input status register bank
`timescale 1ns/1ps
module clock_input_status_registers_tb;
   import clk_status_pkg::*;
   // ==========================================
   // Signals
   logic clk, resetn, regWrite, regRead, regRdValid;
   logic [7:0] regAddr, regWrData, regRdData, ackDelay, rdv, lo, mid, v;
   logic inputOneSelected, inputTwoSelected, inputOneSignalLoss, inputTwoSignalLoss, referenceSignalLoss;
   logic inputOneFreqOffset, inputTwoFreqOffset, pllUnlocked, coarseSkewWrite, coarseSkewAckToggle, historySample;
   logic [18:0] secondInputDivider;
   rate_band_t inputOneRateBand, inputTwoRateBand;
   band_window_t inputOneWindow, inputTwoWindow;
   logic inputOneActive, inputTwoActive, coarseSkewBusy, holdoverHistoryValid;
   logic [2:0] top, bOne, bTwo;
   integer seed = 32'hb277f625;
   integer failures = 0;
   integer testsRun = 0;
   int i;

   clock_input_status_registers #(.HISTORY_DEPTH(4)) dut (
      .clk(clk), .resetn(resetn), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
      .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
      .inputOneSelected(inputOneSelected), .inputTwoSelected(inputTwoSelected),
      .inputOneSignalLoss(inputOneSignalLoss), .inputTwoSignalLoss(inputTwoSignalLoss),
      .referenceSignalLoss(referenceSignalLoss), .inputOneFreqOffset(inputOneFreqOffset),
      .inputTwoFreqOffset(inputTwoFreqOffset), .pllUnlocked(pllUnlocked), .coarseSkewWrite(coarseSkewWrite),
      .coarseSkewAckToggle(coarseSkewAckToggle), .historySample(historySample),
      .secondInputDivider(secondInputDivider), .inputOneRateBand(inputOneRateBand),
      .inputTwoRateBand(inputTwoRateBand), .inputOneWindow(inputOneWindow), .inputTwoWindow(inputTwoWindow),
      .inputOneActive(inputOneActive), .inputTwoActive(inputTwoActive), .coarseSkewBusy(coarseSkewBusy),
      .holdoverHistoryValid(holdoverHistoryValid)
   );

   skew_engine_model partner (
      .clk(clk), .resetn(resetn), .skewWrite(coarseSkewWrite), .ackDelay(ackDelay),
      .ackToggle(coarseSkewAckToggle)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ==========================================
   // Helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : wr

   // Read data is taken one cycle after the strobe, when the valid pulse stands
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      check(regRdValid, 1'b1);
      d = regRdData;
   endtask : rd

   task automatic set_status(input logic [7:0] s);
      @(posedge clk);
      {inputOneSelected, inputTwoSelected, inputOneSignalLoss, inputTwoSignalLoss} <= s[7:4];
      {referenceSignalLoss, inputOneFreqOffset, inputTwoFreqOffset, pllUnlocked} <= s[3:0];
   endtask : set_status

   task automatic skew_run(input logic [7:0] dly);
      @(posedge clk);
      ackDelay <= dly;
      coarseSkewWrite <= 1'b1;
      @(posedge clk);
      coarseSkewWrite <= 1'b0;
      #1;
      check(coarseSkewBusy, 1'b1);
      if (dly > 8'h08) begin
         rd(8'h82, rdv);
         check(rdv[7], 1'b1);
      end
      repeat (dly + 12) @(posedge clk);
      rd(8'h82, rdv);
      check({rdv[7], coarseSkewBusy}, 2'b00);
   endtask : skew_run

   function automatic logic [20:0] window_of(input logic [2:0] c);
      case (c)
         3'h0: window_of = {10'h00a, 10'h01b, 1'b1};
         3'h1: window_of = {10'h019, 10'h036, 1'b1};
         3'h2: window_of = {10'h032, 10'h069, 1'b1};
         3'h3: window_of = {10'h05f, 10'h0d7, 1'b1};
         3'h4: window_of = {10'h0be, 10'h1b3, 1'b1};
         3'h5: window_of = {10'h177, 10'h2c6, 1'b1};
         default: window_of = 21'h000000;
      endcase
   endfunction : window_of

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // Whole run needs under a thousand cycles; this is over twenty times that
   initial begin
      #(100 * 20000);
      failures++;
      report_and_stop;
   end

   // ==========================================
   // Scenarios
   initial begin
      resetn <= 1'b0;
      {regWrite, regRead, coarseSkewWrite, historySample} <= 4'h0;
      regAddr <= 8'h00;
      regWrData <= 8'h00;
      ackDelay <= 8'h01;
      {inputOneSelected, inputTwoSelected, inputOneSignalLoss, inputTwoSignalLoss} <= 4'h0;
      {referenceSignalLoss, inputOneFreqOffset, inputTwoFreqOffset, pllUnlocked} <= 4'h0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      repeat (6) @(posedge clk);
      check(secondInputDivider, 19'h00000);
      rd(8'h37, rdv);
      check(rdv, 8'h00);
      rd(8'h55, rdv);
      check(rdv, 8'h00);
      for (i = 0; i < 16; i++) begin
         {lo, mid} = 16'($random(seed));
         top = 3'($random(seed));
         bOne = 3'($unsigned($random(seed)) % 6);
         bTwo = 3'($unsigned($random(seed)) % 6);
         if (i == 0) begin
            {lo, mid, top, bOne, bTwo} = {8'hff, 8'h00, 3'h7, 3'h5, 3'h0};
         end
         wr(8'h30, lo);
         wr(8'h2f, mid);
         wr(8'h2e, {5'h1f, top});
         wr(8'h37, {2'h3, bTwo, bOne});
         @(posedge clk);
         check(secondInputDivider, {top, mid, lo});
         rd(8'h30, rdv);
         check(rdv, lo);
         rd(8'h37, rdv);
         check(rdv, {2'h0, bTwo, bOne});
         check({inputTwoRateBand, inputOneRateBand}, {bTwo, bOne});
         check(inputOneWindow, window_of(bOne));
         check(inputTwoWindow, window_of(bTwo));
      end
      for (i = 0; i < 24; i++) begin
         v = 8'($random(seed));
         if (v[7] && v[6]) begin
            v[6] = 1'b0;
         end
         set_status(v);
         wr(8'h80, 8'hff);
         wr(8'h81, 8'hff);
         wr(8'h82, 8'hff);
         repeat (5) @(posedge clk);
         rd(8'h80, rdv);
         check(rdv, {6'h00, v[6] & ~v[4], v[7] & ~v[5]});
         check({inputTwoActive, inputOneActive}, {v[6] & ~v[4], v[7] & ~v[5]});
         rd(8'h81, rdv);
         check(rdv, {5'h00, v[4], v[5], v[3]});
         rd(8'h82, rdv);
         check(rdv & 8'hbf, {5'h00, v[1], v[2], v[0]});
      end
      skew_run(8'h01);
      skew_run(8'h14);
      set_status(8'h80);
      repeat (8) @(posedge clk);
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         historySample <= 1'b1;
         @(posedge clk);
         historySample <= 1'b0;
         if (i == 2) begin
            repeat (4) @(posedge clk);
            check(holdoverHistoryValid, 1'b0);
         end
      end
      repeat (4) @(posedge clk);
      check(holdoverHistoryValid, 1'b1);
      rd(8'h82, rdv);
      check(rdv & 8'h40, 8'h40);
      set_status(8'h00);
      repeat (10) @(posedge clk);
      rd(8'h82, rdv);
      check({rdv[6], holdoverHistoryValid}, 2'b00);
      // Reset in mid-run must bring back the divide-by-one divider and band code zero
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      check({secondInputDivider, inputTwoRateBand, inputOneRateBand}, 25'h0000000);
      repeat (2) @(posedge clk);
      check(inputTwoWindow, window_of(3'h0));
      report_and_stop;
   end
endmodule : clock_input_status_registers_tb
